// [design/calendar_date_counter.sv]
// Calendar date counter with time of day behind an AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`default_nettype none

module calendar_date_counter #(
	parameter int unsigned TICK_COUNT = cal_pkg::TICK_CYCLES
) (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [cal_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]                 s_axi_awprot,
	input  wire logic                       s_axi_awvalid,
	output var  logic                       s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output var  logic                       s_axi_wready,
	output var  logic [1:0]                 s_axi_bresp,
	output var  logic                       s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [cal_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]                 s_axi_arprot,
	input  wire logic                       s_axi_arvalid,
	output var  logic                       s_axi_arready,
	output var  logic [31:0]                s_axi_rdata,
	output var  logic [1:0]                 s_axi_rresp,
	output var  logic                       s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       network_handle_command,
	input  wire logic [31:0]                network_calendar
);
	import cal_pkg::*;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
		hits = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
	endfunction : hits

	// A calendar word is legal only if every field lies in its range
	function automatic logic cal_ok(input logic [31:0] w);
		weekday_t wd;
		day_t     md;
		month_t   mo;
		year_t    yr;
		wd     = w[WD_LSB +: WD_W];
		md     = w[MD_LSB +: MD_W];
		mo     = w[MO_LSB +: MO_W];
		yr     = w[YR_LSB +: YR_W];
		cal_ok = (wd >= SUNDAY) && (wd <= SATURDAY)
			&& (mo >= JANUARY) && (mo <= DECEMBER)
			&& (yr <= YEAR_MAX)
			&& (md >= FIRST_DAY) && (md <= days_in_month(mo, yr));
	endfunction : cal_ok

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merge[8*i +: 8] = data[8*i +: 8];
			end
		end
	endfunction : merge

	// ----------------------------------------------------------------
	// Internal state and nets
	// ----------------------------------------------------------------
	cal_if cal ();

	logic                aw_hold_q;
	logic [ADDR_W-1:0]   aw_addr_q;
	logic                w_hold_q;
	logic [31:0]         w_data_q;
	logic [3:0]          w_strb_q;
	logic [IDX_W-1:0]    index_q;
	logic                net_src_q;
	logic                reject_q;
	logic                do_write;
	logic                host_cal_set;
	logic                host_tod_set;
	logic                index_wr;
	logic                wr_err;
	logic                net_ok;
	logic [31:0]         cal_word;
	logic [31:0]         tod_word;
	logic [31:0]         wr_word;
	logic [31:0]         set_word;
	logic [31:0]         rd_word;
	logic [1:0]          rd_resp;
	minsec_t             second;
	minsec_t             minute;
	hour_t               hour;
	logic                day_roll;

	assign cal_word = pack_cal(cal.weekday_field, cal.month_day_field, cal.month, cal.year);

	// Live time word: seconds, minutes and hours in their own bytes
	always_comb begin
		tod_word                     = 32'h0000_0000;
		tod_word[SEC_LSB +: MS_W]    = second;
		tod_word[MIN_LSB +: MS_W]    = minute;
		tod_word[HR_LSB +: HR_W]     = hour;
	end

	// ----------------------------------------------------------------
	// Write address and write data channels, taken in either order
	// ----------------------------------------------------------------
	assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q     <= 1'b0;
			aw_addr_q     <= '0;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_q     <= 1'b1;
			aw_addr_q     <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (do_write || !aw_hold_q) begin
			aw_hold_q     <= 1'b0;
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_q     <= 1'b0;
			w_data_q     <= '0;
			w_strb_q     <= '0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_hold_q     <= 1'b1;
			w_data_q     <= s_axi_wdata;
			w_strb_q     <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (do_write || !w_hold_q) begin
			w_hold_q     <= 1'b0;
			s_axi_wready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Write decode; a bad field value is refused whole, never clipped
	// ----------------------------------------------------------------
	always_comb begin
		host_cal_set = 1'b0;
		host_tod_set = 1'b0;
		index_wr     = 1'b0;
		wr_err       = 1'b0;
		wr_word      = 32'h0000_0000;
		if (do_write) begin
			if (hits(aw_addr_q, CAL_OFS)) begin
				wr_word      = merge(cal_word, w_data_q, w_strb_q);
				host_cal_set = cal_ok(wr_word);
				wr_err       = !cal_ok(wr_word);
			end else if (hits(aw_addr_q, TIME_OFS)) begin
				wr_word      = merge(tod_word, w_data_q, w_strb_q);
				host_tod_set = (wr_word[SEC_LSB +: MS_W] <= MINSEC_MAX)
					&& (wr_word[MIN_LSB +: MS_W] <= MINSEC_MAX)
					&& (wr_word[HR_LSB +: HR_W] <= HOUR_MAX);
				wr_err       = !host_tod_set;
			end else if (hits(aw_addr_q, INDEX_OFS)) begin
				index_wr     = w_strb_q[0];
			end else if (hits(aw_addr_q, FIELD_OFS) || hits(aw_addr_q, STATUS_OFS)) begin
				wr_err       = 1'b0;
			end else begin
				wr_err       = 1'b1;
			end
		end
	end

	// Host command has priority; a network update in that same cycle is dropped
	assign net_ok   = network_handle_command && cal_ok(network_calendar) && !host_cal_set;
	assign set_word = host_cal_set ? wr_word : network_calendar;

	assign cal.set_valid     = host_cal_set || net_ok;
	assign cal.set_weekday   = set_word[WD_LSB +: WD_W];
	assign cal.set_month_day = set_word[MD_LSB +: MD_W];
	assign cal.set_month     = set_word[MO_LSB +: MO_W];
	assign cal.set_year      = set_word[YR_LSB +: YR_W];
	assign cal.day_roll      = day_roll;

	// Write response one cycle after both halves are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Software-visible control and status
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			index_q <= '0;
		end else if (index_wr) begin
			index_q <= w_data_q[IDX_W-1:0];
		end
	end

	// Source of the last applied calendar set, and whether any write was refused since the last good calendar or time write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			net_src_q <= 1'b0;
			reject_q  <= 1'b0;
		end else begin
			if (host_cal_set) begin
				net_src_q <= 1'b0;
			end else if (net_ok) begin
				net_src_q <= 1'b1;
			end
			if (wr_err) begin
				reject_q <= 1'b1;
			end else if (host_cal_set || host_tod_set) begin
				reject_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read decode and read channel
	// ----------------------------------------------------------------
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_resp = RESP_OKAY;
		if (hits(s_axi_araddr, CAL_OFS)) begin
			rd_word = cal_word;
		end else if (hits(s_axi_araddr, TIME_OFS)) begin
			rd_word = tod_word;
		end else if (hits(s_axi_araddr, INDEX_OFS)) begin
			rd_word[IDX_W-1:0] = index_q;
		end else if (hits(s_axi_araddr, FIELD_OFS)) begin
			case (readback_e'(index_q))
				WEEKDAY_READBACK:   rd_word[WD_W-1:0] = cal.weekday_field;
				MONTH_DAY_READBACK: rd_word[MD_W-1:0] = cal.month_day_field;
				MONTH_READBACK:     rd_word[MO_W-1:0] = cal.month;
				YEAR_READBACK:      rd_word[YR_W-1:0] = cal.year;
				default:            rd_word           = 32'h0000_0000;
			endcase
		end else if (hits(s_axi_araddr, STATUS_OFS)) begin
			rd_word[ST_LEAP_BIT] = is_leap(cal.year);
			rd_word[ST_NET_BIT]  = net_src_q;
			rd_word[ST_REJ_BIT]  = reject_q;
		end else begin
			rd_resp = RESP_SLVERR;
		end
	end

	// Data is captured at the address handshake so it cannot tear while rvalid waits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_resp;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Counters
	// ----------------------------------------------------------------
	time_of_day_counter #(
		.TICK_COUNT (TICK_COUNT)
	) u_tod (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.set_valid  (host_tod_set),
		.set_second (wr_word[SEC_LSB +: MS_W]),
		.set_minute (wr_word[MIN_LSB +: MS_W]),
		.set_hour   (wr_word[HR_LSB +: HR_W]),
		.second     (second),
		.minute     (minute),
		.hour       (hour),
		.day_roll   (day_roll)
	);

	calendar_keeper u_keeper (
		.aclk    (aclk),
		.aresetn (aresetn),
		.cal     (cal.keeper)
	);

endmodule : calendar_date_counter

`default_nettype wire

// [design/calendar_keeper.sv]
// Weekday, day of month, month and year registers with leap-aware advance
`default_nettype none

module calendar_keeper (
	input  wire logic aclk,
	input  wire logic aresetn,
	cal_if.keeper     cal
);
	import cal_pkg::*;

	day_t last_day;

	assign last_day = days_in_month(cal.month, cal.year);

	// Weekday runs 1 (Sunday) to 7 (Saturday) and wraps back to Sunday
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cal.weekday_field <= RST_WEEKDAY;
		end else if (cal.set_valid) begin
			cal.weekday_field <= cal.set_weekday;
		end else if (cal.day_roll) begin
			cal.weekday_field <= (cal.weekday_field == SATURDAY) ? SUNDAY : cal.weekday_field + 1'b1;
		end
	end

	// Date carries day into month and month into year; a set wins over a roll
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cal.month_day_field <= RST_MONTH_DAY;
			cal.month           <= RST_MONTH;
			cal.year            <= RST_YEAR;
		end else if (cal.set_valid) begin
			cal.month_day_field <= cal.set_month_day;
			cal.month           <= cal.set_month;
			cal.year            <= cal.set_year;
		end else if (cal.day_roll) begin
			if (cal.month_day_field >= last_day) begin
				cal.month_day_field <= FIRST_DAY;
				if (cal.month == DECEMBER) begin
					cal.month <= JANUARY;
					cal.year  <= (cal.year == YEAR_MAX) ? '0 : cal.year + 1'b1;
				end else begin
					cal.month <= cal.month + 1'b1;
				end
			end else begin
				cal.month_day_field <= cal.month_day_field + 1'b1;
			end
		end
	end

endmodule : calendar_keeper

`default_nettype wire

// [design/time_of_day_counter.sv]
// Seconds prescaler and 24-hour time-of-day counter with midnight pulse
`default_nettype none

module time_of_day_counter #(
	parameter int unsigned TICK_COUNT = cal_pkg::TICK_CYCLES
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             set_valid,
	input  wire cal_pkg::minsec_t set_second,
	input  wire cal_pkg::minsec_t set_minute,
	input  wire cal_pkg::hour_t   set_hour,
	output var  cal_pkg::minsec_t second,
	output var  cal_pkg::minsec_t minute,
	output var  cal_pkg::hour_t   hour,
	output var  logic             day_roll
);
	import cal_pkg::*;

	logic [TICK_W-1:0] tick_cnt_q;
	logic              tick;
	logic              at_midnight;

	assign tick        = (tick_cnt_q == TICK_W'(TICK_COUNT - 1));
	assign at_midnight = (second == MINSEC_MAX) && (minute == MINSEC_MAX) && (hour == HOUR_MAX);

	// Prescaler restarts on a set so the first second after it is a full one
	always_ff @(posedge aclk) begin
		if (!aresetn || set_valid || tick) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
		end
	end

	// Seconds, minutes and hours; a set overrides a tick in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			second <= '0;
			minute <= '0;
			hour   <= '0;
		end else if (set_valid) begin
			second <= set_second;
			minute <= set_minute;
			hour   <= set_hour;
		end else if (tick) begin
			if (second == MINSEC_MAX) begin
				second <= '0;
				if (minute == MINSEC_MAX) begin
					minute <= '0;
					hour   <= (hour == HOUR_MAX) ? '0 : hour + 1'b1;
				end else begin
					minute <= minute + 1'b1;
				end
			end else begin
				second <= second + 1'b1;
			end
		end
	end

	// One-cycle pulse as the hour wraps from 23 to 0
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			day_roll <= 1'b0;
		end else begin
			day_roll <= tick && at_midnight && !set_valid;
		end
	end

endmodule : time_of_day_counter

`default_nettype wire

// [inc/cal_if.sv]
// Carrier between the register front end and the calendar keeper
`default_nettype none

interface cal_if;
	logic              set_valid;
	cal_pkg::weekday_t set_weekday;
	cal_pkg::day_t     set_month_day;
	cal_pkg::month_t   set_month;
	cal_pkg::year_t    set_year;
	logic              day_roll;
	cal_pkg::weekday_t weekday_field;
	cal_pkg::day_t     month_day_field;
	cal_pkg::month_t   month;
	cal_pkg::year_t    year;

	modport keeper (
		input  set_valid, set_weekday, set_month_day, set_month, set_year, day_roll,
		output weekday_field, month_day_field, month, year
	);
	modport ctrl (
		output set_valid, set_weekday, set_month_day, set_month, set_year, day_roll,
		input  weekday_field, month_day_field, month, year
	);
endinterface : cal_if

`default_nettype wire

// [inc/cal_pkg.sv]
// Shared constants, types and helper functions for the calendar date counter
`default_nettype none

package cal_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned SECOND_NS     = 1_000_000_000;
	localparam int unsigned TICK_CYCLES   = SECOND_NS / CLK_PERIOD_NS;
	localparam int unsigned TICK_W        = 27;

	// ----------------------------------------------------------------
	// Register map (byte addresses, one aligned word each)
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W     = 8;
	localparam logic [7:0]  CAL_OFS    = 8'h00;
	localparam logic [7:0]  TIME_OFS   = 8'h04;
	localparam logic [7:0]  INDEX_OFS  = 8'h08;
	localparam logic [7:0]  FIELD_OFS  = 8'h0C;
	localparam logic [7:0]  STATUS_OFS = 8'h10;

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Field layout of the calendar and time words
	// ----------------------------------------------------------------
	localparam int unsigned WD_LSB  = 0;
	localparam int unsigned WD_W    = 3;
	localparam int unsigned MD_LSB  = 8;
	localparam int unsigned MD_W    = 5;
	localparam int unsigned MO_LSB  = 16;
	localparam int unsigned MO_W    = 4;
	localparam int unsigned YR_LSB  = 24;
	localparam int unsigned YR_W    = 7;
	localparam int unsigned SEC_LSB = 0;
	localparam int unsigned MIN_LSB = 8;
	localparam int unsigned HR_LSB  = 16;
	localparam int unsigned MS_W    = 6;
	localparam int unsigned HR_W    = 5;
	localparam int unsigned IDX_W   = 2;

	localparam int unsigned ST_LEAP_BIT = 0;
	localparam int unsigned ST_NET_BIT  = 1;
	localparam int unsigned ST_REJ_BIT  = 2;

	typedef logic [WD_W-1:0]  weekday_t;
	typedef logic [MD_W-1:0]  day_t;
	typedef logic [MO_W-1:0]  month_t;
	typedef logic [YR_W-1:0]  year_t;
	typedef logic [MS_W-1:0]  minsec_t;
	typedef logic [HR_W-1:0]  hour_t;

	// Readback index of each calendar field
	typedef enum logic [1:0] {
		WEEKDAY_READBACK   = 2'h0,
		MONTH_DAY_READBACK = 2'h1,
		MONTH_READBACK     = 2'h2,
		YEAR_READBACK      = 2'h3
	} readback_e;

	// ----------------------------------------------------------------
	// Limits and reset values
	// ----------------------------------------------------------------
	localparam weekday_t SUNDAY      = 3'h1;
	localparam weekday_t SATURDAY    = 3'h7;
	localparam day_t     FIRST_DAY   = 5'h01;
	localparam month_t   JANUARY     = 4'h1;
	localparam month_t   FEBRUARY    = 4'h2;
	localparam month_t   APRIL       = 4'h4;
	localparam month_t   JUNE        = 4'h6;
	localparam month_t   SEPTEMBER   = 4'h9;
	localparam month_t   NOVEMBER    = 4'hB;
	localparam month_t   DECEMBER    = 4'hC;
	localparam year_t    YEAR_MAX    = 7'h63;
	localparam minsec_t  MINSEC_MAX  = 6'h3B;
	localparam hour_t    HOUR_MAX    = 5'h17;
	localparam day_t     DAYS_28     = 5'h1C;
	localparam day_t     DAYS_29     = 5'h1D;
	localparam day_t     DAYS_30     = 5'h1E;
	localparam day_t     DAYS_31     = 5'h1F;

	localparam weekday_t RST_WEEKDAY   = 3'h7;
	localparam day_t     RST_MONTH_DAY = 5'h01;
	localparam month_t   RST_MONTH     = 4'h1;
	localparam year_t    RST_YEAR      = 7'h00;

	// ----------------------------------------------------------------
	// Calendar helpers
	// ----------------------------------------------------------------
	// Every year 2000..2099 divisible by four is leap, 2000 included
	function automatic logic is_leap(input year_t yr);
		is_leap = (yr[1:0] == 2'h0);
	endfunction : is_leap

	function automatic day_t days_in_month(input month_t mo, input year_t yr);
		if (mo == FEBRUARY) begin
			days_in_month = is_leap(yr) ? DAYS_29 : DAYS_28;
		end else if (mo == APRIL || mo == JUNE || mo == SEPTEMBER || mo == NOVEMBER) begin
			days_in_month = DAYS_30;
		end else begin
			days_in_month = DAYS_31;
		end
	endfunction : days_in_month

	function automatic logic [31:0] pack_cal(input weekday_t wd, input day_t md, input month_t mo, input year_t yr);
		pack_cal                    = 32'h0000_0000;
		pack_cal[WD_LSB +: WD_W]    = wd;
		pack_cal[MD_LSB +: MD_W]    = md;
		pack_cal[MO_LSB +: MO_W]    = mo;
		pack_cal[YR_LSB +: YR_W]    = yr;
	endfunction : pack_cal

endpackage : cal_pkg

`default_nettype wire

// [tb/calendar_date_counter_asserts.sv]
// Bus handshake and calendar range checker on the calendar date counter ports
`default_nettype none

module calendar_date_counter_asserts (
	input wire logic                       aclk,
	input wire logic                       aresetn,
	input wire logic                       s_axi_awvalid,
	input wire logic                       s_axi_awready,
	input wire logic                       s_axi_wvalid,
	input wire logic                       s_axi_wready,
	input wire logic [1:0]                 s_axi_bresp,
	input wire logic                       s_axi_bvalid,
	input wire logic                       s_axi_bready,
	input wire logic [cal_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic                       s_axi_arvalid,
	input wire logic                       s_axi_arready,
	input wire logic [31:0]                s_axi_rdata,
	input wire logic [1:0]                 s_axi_rresp,
	input wire logic                       s_axi_rvalid,
	input wire logic                       s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	import cal_pkg::*;
	// One clock domain, so one default clocking and reset
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	reset_idle_a: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !s_axi_arready)
		else $error("outputs not idle after reset");
	// Both halves held one edge after the take, response registered one edge later
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid)
		else $error("no write response after address and data");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read data after address");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before taken");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while data pending");
	unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h13
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
	// A live calendar word can never hold a zero weekday or day of month, nor a month or year out of range
	cal_range_a: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr == CAL_OFS |=> s_axi_rdata[2:0] != 3'h0 && s_axi_rdata[12:8] != 5'h00
		&& s_axi_rdata[19:16] inside {[4'h1:4'hC]} && s_axi_rdata[30:24] < 7'h64)
		else $error("calendar field out of range");
	field_width_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == FIELD_OFS
		|=> s_axi_rdata[31:7] == 25'h0) else $error("field readback too wide");
endmodule : calendar_date_counter_asserts

bind calendar_date_counter calendar_date_counter_asserts calendar_date_counter_asserts_inst (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);

`default_nettype wire

// [tb/calendar_date_counter_tb_top.sv]
// Register-level testbench for the calendar date counter
`default_nettype none

module calendar_date_counter_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import cal_pkg::*;
	localparam int TICKS = 4; // Short second keeps rollovers quick
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, network_calendar;
	logic        network_handle_command;
	int          num_errors = 0, num_checks = 0, fv[4];

	calendar_date_counter #(.TICK_COUNT(TICKS)) calendar_date_counter_inst (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .network_handle_command, .network_calendar
	);
	network_time_source network_time_source_inst (.aclk, .network_handle_command, .network_calendar);

	// 100 MHz clock
	initial begin
		forever #5 aclk = ~aclk;
	end

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// A wait that runs out ends the run at once
	task automatic limit(input int n);
		if (n >= 50) begin
			chk("handshake", 32'h1, 32'h0);
			tally_and_finish();
		end
	endtask : limit

	function automatic logic [31:0] cw(input int wd, input int md, input int mo, input int yr);
		cw = {1'b0, 7'(yr), 4'h0, 4'(mo), 3'h0, 5'(md), 5'h00, 3'(wd)};
	endfunction : cw

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 50);
		s_axi_bready <= 1'b0;
		limit(n);
		chk("bresp", 32'(er), 32'(s_axi_bresp));
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 50);
		s_axi_rready <= 1'b0;
		limit(n);
		chk("rdata", ed, s_axi_rdata);
		chk("rresp", 32'(er), 32'(s_axi_rresp));
	endtask : rd

	// Date set, clock put one second before midnight, then the advance read back
	task automatic roll(input logic [31:0] from_w, input logic [31:0] to_w);
		wr(CAL_OFS, from_w, RESP_OKAY);
		wr(TIME_OFS, 32'h0017_3B3B, RESP_OKAY);
		repeat (3 * TICKS) @(posedge aclk);
		rd(CAL_OFS, to_w, RESP_OKAY);
	endtask : roll

	// Main sequence
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(CAL_OFS, cw(7, 1, 1, 0), RESP_OKAY);
		roll(cw(7, 28, 2, 24), cw(1, 29, 2, 24));
		// Three full seconds have ticked since the midnight wrap
		rd(TIME_OFS, 32'h0000_0003, RESP_OKAY);
		rd(STATUS_OFS, 32'h0000_0001, RESP_OKAY);
		roll(cw(3, 28, 2, 23), cw(4, 1, 3, 23));
		roll(cw(5, 30, 4, 10), cw(6, 1, 5, 10));
		roll(cw(6, 31, 12, 99), cw(7, 1, 1, 0));
		wr(CAL_OFS, cw(0, 1, 1, 0), RESP_SLVERR);
		wr(CAL_OFS, cw(1, 31, 4, 0), RESP_SLVERR);
		wr(CAL_OFS, cw(1, 1, 13, 0), RESP_SLVERR);
		wr(CAL_OFS, cw(1, 1, 1, 100), RESP_SLVERR);
		wr(CAL_OFS, cw(1, 29, 2, 23), RESP_SLVERR);
		wr(TIME_OFS, 32'h0018_0000, RESP_SLVERR);
		wr(TIME_OFS, 32'h0000_3C00, RESP_SLVERR);
		rd(STATUS_OFS, 32'h0000_0005, RESP_OKAY);
		rd(CAL_OFS, cw(7, 1, 1, 0), RESP_OKAY);
		wr(CAL_OFS, cw(4, 19, 11, 57), RESP_OKAY);
		fv = '{4, 19, 11, 57};
		for (int i = 0; i < 4; i++) begin
			wr(INDEX_OFS, 32'(i), RESP_OKAY);
			rd(FIELD_OFS, 32'(fv[i]), RESP_OKAY);
		end
		network_time_source_inst.send(cw(2, 15, 6, 33));
		rd(CAL_OFS, cw(2, 15, 6, 33), RESP_OKAY);
		rd(STATUS_OFS, 32'h0000_0002, RESP_OKAY);
		network_time_source_inst.send(cw(2, 31, 6, 33));
		rd(CAL_OFS, cw(2, 15, 6, 33), RESP_OKAY);
		rd(8'h20, 32'h0, RESP_SLVERR);
		wr(8'h20, 32'hFFFF_FFFF, RESP_SLVERR);
		tally_and_finish();
	end
endmodule : calendar_date_counter_tb_top

`default_nettype wire

// [tb/network_time_source.sv]
// Network time service model that pushes calendar words
`default_nettype none

module network_time_source (
	input  wire logic        aclk,
	output var  logic        network_handle_command,
	output var  logic [31:0] network_calendar
);
	timeunit 1ns;
	timeprecision 1ps;

	// Quiet line at start
	initial begin
		network_handle_command = 1'b0;
		network_calendar       = 32'h0000_0000;
	end

	// One-cycle update; word inverted after so the sent value does not stay on the line
	task automatic send(input logic [31:0] w);
		@(posedge aclk);
		network_handle_command <= 1'b1;
		network_calendar       <= w;
		@(posedge aclk);
		network_handle_command <= 1'b0;
		network_calendar       <= ~w;
	endtask : send
endmodule : network_time_source

`default_nettype wire
